// ### verilog/bbc_regs.sv
// Bulk buffer byte-count registers and handshake-event status/mask with interrupt.
// Assumes the engine pulses count updates and events synchronous to i_core_clk.
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/100ps
module bbc_regs #(
  parameter int ADDR_W = 10
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [ADDR_W-1:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Receive counts from the engine
  input wire logic i_a_rx_done,
  input wire logic i_b_rx_done,
  input wire logic [8:0] i_rx_count,
  input wire logic i_rx_full,
  // Transmit counts to the engine
  output logic [8:0] o_a_tx_count,
  output logic o_a_tx_full,
  output logic [8:0] o_b_tx_count,
  output logic o_b_tx_full,
  // Handshake events, one-cycle pulses in status bit order
  input wire logic [7:0] i_hs_event,
  // Interrupt
  output logic o_handshake_event_irq
);

  logic [8:0] a_rx_cnt_r;
  logic a_rx_full_r;
  logic [8:0] b_rx_cnt_r;
  logic b_rx_full_r;
  logic [8:0] a_tx_cnt_r;
  logic a_tx_full_r;
  logic [8:0] b_tx_cnt_r;
  logic b_tx_full_r;
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [7:0] mask_r;
  logic ack_r;
  logic [31:0] rdat_r;

  function automatic logic [7:0] upper_byte(input logic full, input logic bit8);
    upper_byte = {6'h00, full, bit8} & bbc_pkg::UPPER_VALID_MASK;
  endfunction

  // Word-aligned decode; bits [1:0] of the address are ignored
  wire logic [7:0] idx = i_wb_adr[9:2];
  wire logic req = i_wb_cyc & i_wb_stb & ~ack_r;
  wire logic wr = req & i_wb_we & i_wb_sel[0];
  wire logic [7:0] wbyte = i_wb_dat[7:0];
  wire logic wr_a_tx_hi = wr & (idx == bbc_pkg::IDX_A_TX_HIGH);
  wire logic wr_a_tx_lo = wr & (idx == bbc_pkg::IDX_A_TX_LOW);
  wire logic wr_b_tx_hi = wr & (idx == bbc_pkg::IDX_B_TX_HIGH);
  wire logic wr_b_tx_lo = wr & (idx == bbc_pkg::IDX_B_TX_LOW);
  wire logic wr_status = wr & (idx == bbc_pkg::IDX_HS_STATUS);
  wire logic wr_mask = wr & (idx == bbc_pkg::IDX_HS_MASK);
  wire logic hit = (idx == bbc_pkg::IDX_A_RX_HIGH) | (idx == bbc_pkg::IDX_A_RX_LOW) |
    (idx == bbc_pkg::IDX_B_RX_HIGH) | (idx == bbc_pkg::IDX_B_RX_LOW) |
    (idx == bbc_pkg::IDX_A_TX_HIGH) | (idx == bbc_pkg::IDX_A_TX_LOW) |
    (idx == bbc_pkg::IDX_B_TX_HIGH) | (idx == bbc_pkg::IDX_B_TX_LOW) |
    (idx == bbc_pkg::IDX_HS_STATUS) | (idx == bbc_pkg::IDX_HS_MASK);
  wire logic rd_req = req & ~i_wb_we;

  // Unmapped reads return zero; writes there are dropped but still acked
  logic [7:0] rsel;
  always_comb
  begin
    case (idx)
      bbc_pkg::IDX_A_RX_HIGH: rsel = upper_byte(a_rx_full_r, a_rx_cnt_r[8]);
      bbc_pkg::IDX_A_RX_LOW: rsel = a_rx_cnt_r[7:0];
      bbc_pkg::IDX_B_RX_HIGH: rsel = upper_byte(b_rx_full_r, b_rx_cnt_r[8]);
      bbc_pkg::IDX_B_RX_LOW: rsel = b_rx_cnt_r[7:0];
      bbc_pkg::IDX_A_TX_HIGH: rsel = upper_byte(a_tx_full_r, a_tx_cnt_r[8]);
      bbc_pkg::IDX_A_TX_LOW: rsel = a_tx_cnt_r[7:0];
      bbc_pkg::IDX_B_TX_HIGH: rsel = upper_byte(b_tx_full_r, b_tx_cnt_r[8]);
      bbc_pkg::IDX_B_TX_LOW: rsel = b_tx_cnt_r[7:0];
      bbc_pkg::IDX_HS_STATUS: rsel = status_r;
      bbc_pkg::IDX_HS_MASK: rsel = mask_r;
      default: rsel = bbc_pkg::RST_BYTE;
    endcase
  end

  // Set after clear so an event landing with a clear is kept
  assign status_nxt = (status_r & ~(wr_status ? wbyte : 8'h00)) | i_hs_event;

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= req;
      rdat_r <= {24'h000000, rsel};
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      a_rx_cnt_r <= bbc_pkg::RST_COUNT;
      a_rx_full_r <= 1'b0;
      b_rx_cnt_r <= bbc_pkg::RST_COUNT;
      b_rx_full_r <= 1'b0;
    end
    else
    begin
      if (i_a_rx_done)
      begin
        a_rx_cnt_r <= i_rx_count;
        a_rx_full_r <= i_rx_full;
      end
      if (i_b_rx_done)
      begin
        b_rx_cnt_r <= i_rx_count;
        b_rx_full_r <= i_rx_full;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      a_tx_cnt_r <= bbc_pkg::RST_COUNT;
      a_tx_full_r <= 1'b0;
      b_tx_cnt_r <= bbc_pkg::RST_COUNT;
      b_tx_full_r <= 1'b0;
    end
    else
    begin
      if (wr_a_tx_lo)
        a_tx_cnt_r[7:0] <= wbyte;
      if (wr_a_tx_hi)
      begin
        a_tx_cnt_r[8] <= wbyte[bbc_pkg::COUNT_BIT_NINE_POS];
        a_tx_full_r <= wbyte[bbc_pkg::FULL_BUFFER_BIT];
      end
      if (wr_b_tx_lo)
        b_tx_cnt_r[7:0] <= wbyte;
      if (wr_b_tx_hi)
      begin
        b_tx_cnt_r[8] <= wbyte[bbc_pkg::COUNT_BIT_NINE_POS];
        b_tx_full_r <= wbyte[bbc_pkg::FULL_BUFFER_BIT];
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      status_r <= bbc_pkg::RST_BYTE;
      mask_r <= bbc_pkg::RST_MASK;
    end
    else
    begin
      status_r <= status_nxt;
      if (wr_mask)
        mask_r <= wbyte;
    end
  end

  assign o_wb_ack = ack_r;
  assign o_wb_dat = rdat_r;
  assign o_a_tx_count = a_tx_cnt_r;
  assign o_a_tx_full = a_tx_full_r;
  assign o_b_tx_count = b_tx_cnt_r;
  assign o_b_tx_full = b_tx_full_r;
  // Level output, so firmware must clear status or set the mask bit to drop it
  assign o_handshake_event_irq = |(status_r & ~mask_r);

  a_irq_level: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    o_handshake_event_irq == |(status_r & ~mask_r))
    else $error("irq does not follow unmasked status");
  a_event_sets: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_hs_event != 8'h00) |=> ((status_r & $past(i_hs_event)) == $past(i_hs_event)))
    else $error("event lost in status");
  a_w1c_clear: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    wr_status |=> ((status_r & $past(wbyte) & ~$past(i_hs_event)) == 8'h00))
    else $error("write one did not clear status");
  a_status_sticky: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    !wr_status |=> ((status_r & $past(status_r)) == $past(status_r)))
    else $error("status bit dropped without clear");
  a_tx_hold: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    wr_a_tx_hi |=> (o_a_tx_full == $past(wbyte[1])) && (o_a_tx_count[8] == $past(wbyte[0])))
    else $error("tx upper bits not held");
  a_tx_low: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    wr_b_tx_lo |=> (o_b_tx_count[7:0] == $past(wbyte)))
    else $error("tx low byte not loaded");
  a_rx_capture: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    i_a_rx_done |=> (a_rx_cnt_r == $past(i_rx_count)) && (a_rx_full_r == $past(i_rx_full)))
    else $error("rx count not captured");
  a_upper_zero: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (req && !i_wb_we && (idx == bbc_pkg::IDX_B_RX_HIGH || idx == bbc_pkg::IDX_A_TX_HIGH))
      |=> (o_wb_dat[7:2] == 6'h00))
    else $error("reserved upper bits not zero");
  a_ack_once: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    o_wb_ack |=> !o_wb_ack)
    else $error("ack held two cycles");

  // Each event line must land in its own status bit
  a_ep2_out_notyet: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    i_hs_event[bbc_pkg::EP2_OUT_NOTYET] |=> status_r[bbc_pkg::EP2_OUT_NOTYET])
    else $error("ep2 out notyet not recorded");
  a_ep0_out_notyet: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    i_hs_event[bbc_pkg::EP0_OUT_NOTYET] |=> status_r[bbc_pkg::EP0_OUT_NOTYET])
    else $error("ep0 out notyet not recorded");
  a_ep2_in_refused: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    i_hs_event[bbc_pkg::EP2_IN_REFUSED] |=> status_r[bbc_pkg::EP2_IN_REFUSED])
    else $error("ep2 in refusal not recorded");
  a_ep1_in_refused: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    i_hs_event[bbc_pkg::EP1_IN_REFUSED] |=> status_r[bbc_pkg::EP1_IN_REFUSED])
    else $error("ep1 in refusal not recorded");
  a_ep0_in_refused: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    i_hs_event[bbc_pkg::EP0_IN_REFUSED] |=> status_r[bbc_pkg::EP0_IN_REFUSED])
    else $error("ep0 in refusal not recorded");
  a_ep2_out_refused: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    i_hs_event[bbc_pkg::EP2_OUT_REFUSED] |=> status_r[bbc_pkg::EP2_OUT_REFUSED])
    else $error("ep2 out refusal not recorded");
  a_ep1_out_refused: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    i_hs_event[bbc_pkg::EP1_OUT_REFUSED] |=> status_r[bbc_pkg::EP1_OUT_REFUSED])
    else $error("ep1 out refusal not recorded");
  a_ep0_out_refused: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    i_hs_event[bbc_pkg::EP0_OUT_REFUSED] |=> status_r[bbc_pkg::EP0_OUT_REFUSED])
    else $error("ep0 out refusal not recorded");

  // A one written to a quiet bit clears exactly that bit
  a_clr_ep2_notyet: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (wr_status && wbyte[bbc_pkg::EP2_OUT_NOTYET] && !i_hs_event[bbc_pkg::EP2_OUT_NOTYET])
      |=> !status_r[bbc_pkg::EP2_OUT_NOTYET])
    else $error("bit 7 not cleared");
  a_clr_ep0_notyet: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (wr_status && wbyte[bbc_pkg::EP0_OUT_NOTYET] && !i_hs_event[bbc_pkg::EP0_OUT_NOTYET])
      |=> !status_r[bbc_pkg::EP0_OUT_NOTYET])
    else $error("bit 6 not cleared");
  a_clr_ep2_in: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (wr_status && wbyte[bbc_pkg::EP2_IN_REFUSED] && !i_hs_event[bbc_pkg::EP2_IN_REFUSED])
      |=> !status_r[bbc_pkg::EP2_IN_REFUSED])
    else $error("bit 5 not cleared");
  a_clr_ep2_out: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (wr_status && wbyte[bbc_pkg::EP2_OUT_REFUSED] && !i_hs_event[bbc_pkg::EP2_OUT_REFUSED])
      |=> !status_r[bbc_pkg::EP2_OUT_REFUSED])
    else $error("bit 4 not cleared");
  a_clr_ep1_in: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (wr_status && wbyte[bbc_pkg::EP1_IN_REFUSED] && !i_hs_event[bbc_pkg::EP1_IN_REFUSED])
      |=> !status_r[bbc_pkg::EP1_IN_REFUSED])
    else $error("bit 3 not cleared");
  a_clr_ep1_out: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (wr_status && wbyte[bbc_pkg::EP1_OUT_REFUSED] && !i_hs_event[bbc_pkg::EP1_OUT_REFUSED])
      |=> !status_r[bbc_pkg::EP1_OUT_REFUSED])
    else $error("bit 2 not cleared");
  a_clr_ep0_in: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (wr_status && wbyte[bbc_pkg::EP0_IN_REFUSED] && !i_hs_event[bbc_pkg::EP0_IN_REFUSED])
      |=> !status_r[bbc_pkg::EP0_IN_REFUSED])
    else $error("bit 1 not cleared");
  a_clr_ep0_out: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (wr_status && wbyte[bbc_pkg::EP0_OUT_REFUSED] && !i_hs_event[bbc_pkg::EP0_OUT_REFUSED])
      |=> !status_r[bbc_pkg::EP0_OUT_REFUSED])
    else $error("bit 0 not cleared");

  // Interrupt timing and mask handling
  a_irq_event: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (((i_hs_event & ~mask_r) != 8'h00) && !wr_mask) |=> o_handshake_event_irq)
    else $error("unmasked event raised no interrupt");
  a_mask_write: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    wr_mask |=> (mask_r == $past(wbyte)))
    else $error("mask write lost");
  a_mask_stable: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    !wr_mask |=> $stable(mask_r))
    else $error("mask changed without write");

  // Count registers move only on their own strobe
  a_tx_hold_b: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    wr_b_tx_hi |=> (o_b_tx_full == $past(wbyte[1])) && (o_b_tx_count[8] == $past(wbyte[0])))
    else $error("b tx upper bits not held");
  a_tx_low_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    wr_a_tx_lo |=> (o_a_tx_count[7:0] == $past(wbyte)))
    else $error("a tx low byte not loaded");
  a_tx_still_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (!wr_a_tx_lo && !wr_a_tx_hi) |=> $stable({o_a_tx_full, o_a_tx_count}))
    else $error("a tx count changed without write");
  a_tx_still_b: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (!wr_b_tx_lo && !wr_b_tx_hi) |=> $stable({o_b_tx_full, o_b_tx_count}))
    else $error("b tx count changed without write");
  a_rx_capture_b: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    i_b_rx_done |=> (b_rx_cnt_r == $past(i_rx_count)) && (b_rx_full_r == $past(i_rx_full)))
    else $error("b rx count not captured");
  a_rx_still_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    !i_a_rx_done |=> $stable({a_rx_full_r, a_rx_cnt_r}))
    else $error("a rx count changed without capture");
  a_rx_still_b: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    !i_b_rx_done |=> $stable({b_rx_full_r, b_rx_cnt_r}))
    else $error("b rx count changed without capture");
  a_sel_gate: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (req && i_wb_we && !i_wb_sel[0]) |=> $stable(mask_r) && $stable(o_a_tx_count) && $stable(o_b_tx_count))
    else $error("write without byte enable took effect");

  // Bus answer shape
  a_ack_follows: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    req |=> o_wb_ack)
    else $error("request not acked");
  a_ack_no_req: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    !req |=> !o_wb_ack)
    else $error("ack without request");
  a_dat_high_zero: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    o_wb_ack |-> (o_wb_dat[31:8] == 24'h000000))
    else $error("read data upper bytes not zero");
  a_unmapped_zero: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (rd_req && !hit) |=> (o_wb_dat == 32'h0000_0000))
    else $error("unmapped read not zero");
  a_upper_all: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (rd_req && (idx == bbc_pkg::IDX_A_RX_HIGH || idx == bbc_pkg::IDX_B_RX_HIGH ||
      idx == bbc_pkg::IDX_A_TX_HIGH || idx == bbc_pkg::IDX_B_TX_HIGH))
      |=> (o_wb_dat[7:2] == 6'h00))
    else $error("upper reserved bits not zero");

  // Readback of each register against its state at the taking edge
  a_rd_a_rx_high: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (rd_req && idx == bbc_pkg::IDX_A_RX_HIGH) |=> (o_wb_dat[1:0] == $past({a_rx_full_r, a_rx_cnt_r[8]})))
    else $error("a rx upper readback wrong");
  a_rd_b_rx_high: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (rd_req && idx == bbc_pkg::IDX_B_RX_HIGH) |=> (o_wb_dat[1:0] == $past({b_rx_full_r, b_rx_cnt_r[8]})))
    else $error("b rx upper readback wrong");
  a_rd_a_tx_high: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (rd_req && idx == bbc_pkg::IDX_A_TX_HIGH) |=> (o_wb_dat[1:0] == $past({a_tx_full_r, a_tx_cnt_r[8]})))
    else $error("a tx upper readback wrong");
  a_rd_b_tx_high: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (rd_req && idx == bbc_pkg::IDX_B_TX_HIGH) |=> (o_wb_dat[1:0] == $past({b_tx_full_r, b_tx_cnt_r[8]})))
    else $error("b tx upper readback wrong");
  a_rd_a_rx_low: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (rd_req && idx == bbc_pkg::IDX_A_RX_LOW) |=> (o_wb_dat[7:0] == $past(a_rx_cnt_r[7:0])))
    else $error("a rx low readback wrong");
  a_rd_b_rx_low: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (rd_req && idx == bbc_pkg::IDX_B_RX_LOW) |=> (o_wb_dat[7:0] == $past(b_rx_cnt_r[7:0])))
    else $error("b rx low readback wrong");
  a_rd_a_tx_low: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (rd_req && idx == bbc_pkg::IDX_A_TX_LOW) |=> (o_wb_dat[7:0] == $past(a_tx_cnt_r[7:0])))
    else $error("a tx low readback wrong");
  a_rd_b_tx_low: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (rd_req && idx == bbc_pkg::IDX_B_TX_LOW) |=> (o_wb_dat[7:0] == $past(b_tx_cnt_r[7:0])))
    else $error("b tx low readback wrong");
  a_rd_status: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (rd_req && idx == bbc_pkg::IDX_HS_STATUS) |=> (o_wb_dat[7:0] == $past(status_r)))
    else $error("status readback wrong");
  a_rd_mask: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (rd_req && idx == bbc_pkg::IDX_HS_MASK) |=> (o_wb_dat[7:0] == $past(mask_r)))
    else $error("mask readback wrong");

  c_irq_rise: cover property (@(posedge i_core_clk) disable iff (!i_nrst) $rose(o_handshake_event_irq));
  c_set_and_clear: cover property (@(posedge i_core_clk) disable iff (!i_nrst) wr_status && (i_hs_event != 8'h00));
  c_full_rx: cover property (@(posedge i_core_clk) disable iff (!i_nrst) i_b_rx_done && i_rx_full);
  c_tx_write: cover property (@(posedge i_core_clk) disable iff (!i_nrst) wr_b_tx_hi);
  c_unmapped_read: cover property (@(posedge i_core_clk) disable iff (!i_nrst) rd_req && !hit);

endmodule

// ### verilog/bbc_pkg.sv
// Constants for the bulk buffer byte-count and handshake-event register bank.
// Assumes a classic Wishbone slave with byte-wide registers, one per aligned word.
package bbc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_A_RX_HIGH = 8'hCE;
  localparam logic [7:0] IDX_A_RX_LOW = 8'hCF;
  localparam logic [7:0] IDX_B_RX_HIGH = 8'hD1;
  localparam logic [7:0] IDX_B_RX_LOW = 8'hD2;
  localparam logic [7:0] IDX_A_TX_HIGH = 8'hD3;
  localparam logic [7:0] IDX_A_TX_LOW = 8'hD4;
  localparam logic [7:0] IDX_B_TX_HIGH = 8'hD5;
  localparam logic [7:0] IDX_B_TX_LOW = 8'hD6;
  localparam logic [7:0] IDX_HS_STATUS = 8'hD7;
  localparam logic [7:0] IDX_HS_MASK = 8'hD9;
  // Upper count register fields
  localparam int FULL_BUFFER_BIT = 1;
  localparam int COUNT_BIT_NINE_POS = 0;
  localparam logic [7:0] UPPER_VALID_MASK = 8'h03;
  // Event bit positions
  localparam int EP2_OUT_NOTYET = 7;
  localparam int EP0_OUT_NOTYET = 6;
  localparam int EP2_IN_REFUSED = 5;
  localparam int EP2_OUT_REFUSED = 4;
  localparam int EP1_IN_REFUSED = 3;
  localparam int EP1_OUT_REFUSED = 2;
  localparam int EP0_IN_REFUSED = 1;
  localparam int EP0_OUT_REFUSED = 0;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_MASK = 8'hFF;
  localparam logic [8:0] RST_COUNT = 9'h000;
  // Buffer base addresses in SRAM, for reference by the engine
  localparam logic [15:0] BUF_A_BASE = 16'h0100;
  localparam logic [15:0] BUF_B_BASE = 16'h0300;
endpackage

// ### sim/bbc_sie_model.sv
// Engine model: pulses receive counts and handshake events into the bank.
// Assumes each task is entered just after a rising edge of the clock.
`timescale 1ns/100ps
module bbc_sie_model (
  // Clock
  input wire logic i_core_clk,
  // Toward the register bank
  output logic o_a_rx_done,
  output logic o_b_rx_done,
  output logic [8:0] o_rx_count,
  output logic o_rx_full,
  output logic [7:0] o_hs_event
);
  initial
  begin
    o_a_rx_done = 1'b0;
    o_b_rx_done = 1'b0;
    o_rx_count = 9'h000;
    o_rx_full = 1'b0;
    o_hs_event = 8'h00;
  end
  // Count lines are not held after the pulse, so they show the inverse
  task automatic rx(input logic a, input logic [8:0] c, input logic f);
    o_rx_count <= c;
    o_rx_full <= f;
    o_a_rx_done <= a;
    o_b_rx_done <= !a;
    @(posedge i_core_clk);
    o_a_rx_done <= 1'b0;
    o_b_rx_done <= 1'b0;
    o_rx_count <= ~c;
    o_rx_full <= ~f;
  endtask
  task automatic ev(input logic [7:0] m);
    o_hs_event <= m;
    @(posedge i_core_clk);
    o_hs_event <= 8'h00;
  endtask
endmodule

// ### sim/test_bbc_regs.sv
// Self-checking bench for the byte-count and handshake-event register bank.
// Assumes the engine model and a Wishbone master driven from here.
`timescale 1ns/100ps
module test_bbc_regs;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [31:0] wdat = 32'h00000000;
  logic [3:0] sel = 4'h0;
  logic [31:0] rdat;
  logic ack, a_done, b_done, full, a_full, b_full, irq;
  logic [8:0] cnt, a_cnt, b_cnt;
  logic [7:0] hs;
  logic [31:0] exp_q[$];
  int err_total = 0;
  int checks_done = 0;
  always #12.5 clk = ~clk;
  bbc_regs i_bbc_regs (.i_core_clk(clk), .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_a_rx_done(a_done), .i_b_rx_done(b_done), .i_rx_count(cnt), .i_rx_full(full),
    .o_a_tx_count(a_cnt), .o_a_tx_full(a_full), .o_b_tx_count(b_cnt), .o_b_tx_full(b_full),
    .i_hs_event(hs), .o_handshake_event_irq(irq));
  bbc_sie_model i_bbc_sie_model (.i_core_clk(clk), .o_a_rx_done(a_done), .o_b_rx_done(b_done),
    .o_rx_count(cnt), .o_rx_full(full), .o_hs_event(hs));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Read data is only valid in the ack cycle, so it is compared there
  always @(posedge clk)
    if (ack === 1'b1 && !we)
      chk(rdat, exp_q.pop_front());
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'($urandom), d};
    sel <= {3'($urandom), 1'b1};
    do @(posedge clk); while (ack !== 1'b1 && ++n < 50);
    if (n >= 50)
      err_total++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    exp_q.push_back({24'h000000, e});
    wb(1'b0, idx, 8'h00);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    summarize();
  end
  initial
  begin
    logic [7:0] h, m;
    logic [8:0] c;
    void'($urandom(32'h6A3A88C3));
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    for (h = 8'hCE; h != 8'hDB; h++)
      rd(h, (h == 8'hD9) ? 8'hFF : 8'h00);
    chk(irq, 1'b0);
    $display("test reset done");
    for (int b = 0; b < 2; b++)
    begin
      c = b ? 9'h000 : 9'($urandom);
      i_bbc_sie_model.rx(!b, c, b[0]);
      rd(b ? 8'hD2 : 8'hCF, c[7:0]);
      rd(b ? 8'hD1 : 8'hCE, {6'h00, b[0], c[8]});
      wb(1'b1, b ? 8'hD2 : 8'hCF, ~c[7:0]);
      rd(b ? 8'hD2 : 8'hCF, c[7:0]);
      h = 8'hD3 + 8'(2 * b);
      wb(1'b1, h, {6'h3F, 1'b1, c[8]});
      rd(h, {6'h00, 1'b1, c[8]});
      wb(1'b1, h + 8'h01, c[7:0]);
      rd(h + 8'h01, c[7:0]);
      chk(b ? {b_full, b_cnt} : {a_full, a_cnt}, {1'b1, c});
    end
    $display("test counts done");
    for (int i = 0; i < 8; i++)
    begin
      m = 8'h01 << i;
      i_bbc_sie_model.ev(m);
      rd(8'hD7, m);
      chk(irq, 1'b0);
      wb(1'b1, 8'hD9, ~m);
      rd(8'hD9, ~m);
      chk(irq, 1'b1);
      wb(1'b1, 8'hD7, ~m);
      rd(8'hD7, m);
      wb(1'b1, 8'hD7, m);
      chk(irq, 1'b0);
      wb(1'b1, 8'hD9, 8'hFF);
    end
    $display("test events done");
    // Clear and a new event land on the same edge; the event must survive
    i_bbc_sie_model.ev(8'h80);
    fork
      wb(1'b1, 8'hD7, 8'h80);
      i_bbc_sie_model.ev(8'h80);
    join
    rd(8'hD7, 8'h80);
    $display("test collision done");
    summarize();
  end
endmodule
